//--- rtl/aisf_pkg.sv
/*
 holds the constants shared by the analog input sample filter
 assumes a 10 MHz system clock and 16-bit converter samples
*/
package aisf_pkg;
   localparam int unsigned CLK_HZ         = 10000000;
   localparam int unsigned SAMPLE_HZ      = 1000;
   localparam int unsigned TICK_CYCLES    = CLK_HZ / SAMPLE_HZ;
   localparam int unsigned NUM_CH         = 4;
   localparam int unsigned CH_W           = 2;
   localparam int unsigned DATA_W         = 16;
   localparam int unsigned NUM_OUT        = 2;
   localparam int unsigned WIN_50         = 20;
   localparam int unsigned WIN_60         = 17;
   localparam int unsigned HIST_D         = 20;
   localparam int unsigned HIST_W         = 5;
   localparam int unsigned SUM_W          = 21;
   localparam int unsigned FIFO_D         = 8;
   localparam int unsigned FIFO_AW        = 3;
   localparam logic [1:0]  SUPP_50        = 2'h0;
   localparam logic [1:0]  SUPP_60        = 2'h1;
   localparam logic [1:0]  SUPP_400       = 2'h2;
   localparam logic [13:0] TICK_LAST      = 14'(TICK_CYCLES - 1);
endpackage

//--- rtl/aisf_fifo.sv
/*
 holds a small valid/ready fifo of parameterised width and depth
 assumes one clock and an asynchronous active-low reset
*/
module aisf_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8,
   parameter int unsigned AW    = 3
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   assign in_ready  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

//--- rtl/aisf_top.sv
/*
 holds the sample filter: 1 kHz sampling, 50/60 Hz running means, output-word guard
 assumes the converter offers a sample per channel on request; enable, mode, ownership and converter inputs are asynchronous
*/
module aisf_top
   import aisf_pkg::*;
(
   input  wire logic                                 clk_sys,
   input  wire logic                                 reset_n,
   input  wire logic [aisf_pkg::NUM_CH-1:0]          ch_enable,
   input  wire logic [aisf_pkg::NUM_CH*2-1:0]        ch_supp,
   output      logic                                 adc_req,
   output      logic [aisf_pkg::CH_W-1:0]            adc_ch,
   input  wire logic                                 adc_valid,
   input  wire logic [aisf_pkg::DATA_W-1:0]          adc_data,
   input  wire logic [aisf_pkg::CH_W-1:0]            rd_ch,
   output      logic [aisf_pkg::DATA_W-1:0]          periph_input_word,
   output      logic                                 word_valid,
   output      logic [aisf_pkg::CH_W-1:0]            word_ch,
   output      logic [aisf_pkg::DATA_W-1:0]          word_data,
   input  wire logic                                 word_ready,
   input  wire logic                                 wr_req,
   input  wire logic                                 wr_sel,
   input  wire logic [aisf_pkg::DATA_W-1:0]          wr_data,
   input  wire logic [aisf_pkg::NUM_OUT-1:0]         tech_own,
   input  wire logic [aisf_pkg::NUM_OUT*aisf_pkg::DATA_W-1:0] tech_data,
   output      logic [aisf_pkg::NUM_OUT*aisf_pkg::DATA_W-1:0] periph_output_word
);
   import aisf_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_PUSH} aisf_state_type;

   typedef struct packed {
      aisf_state_type                  state;
      logic [13:0]                     tick_cnt;
      logic [CH_W-1:0]                 ch;
      logic                            adc_req;
      logic [NUM_CH*HIST_W-1:0]        wr_idx;
      logic [NUM_CH*SUM_W-1:0]         sum50;
      logic [NUM_CH*SUM_W-1:0]         sum60;
      logic [DATA_W-1:0]               result;
      logic                            push_valid;
      logic [NUM_CH*DATA_W-1:0]        words;
      logic [DATA_W-1:0]               rd_word;
      logic [NUM_OUT*DATA_W-1:0]       out_words;
      logic [NUM_OUT*DATA_W-1:0]       prog_words;
      logic                            fifo_valid;
      logic [CH_W-1:0]                 fifo_ch;
      logic [DATA_W-1:0]               fifo_data;
   } aisf_state_reg_type;

   aisf_state_reg_type st_reg;
   aisf_state_reg_type st_next;

   // per-channel sample history, 20 deep covers both windows
   logic [DATA_W-1:0] hist_mem [NUM_CH*HIST_D];

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // synchronisers for asynchronous controls and converter handshake
   logic [NUM_CH-1:0]         en_s1_reg;
   logic [NUM_CH-1:0]         en_s2_reg;
   logic [NUM_CH*2-1:0]       supp_s1_reg;
   logic [NUM_CH*2-1:0]       supp_s2_reg;
   logic                      av_s1_reg;
   logic                      av_s2_reg;
   logic [DATA_W-1:0]         ad_s1_reg;
   logic [DATA_W-1:0]         ad_s2_reg;
   logic [NUM_OUT-1:0]        own_s1_reg;
   logic [NUM_OUT-1:0]        own_s2_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         en_s1_reg   <= '0;
         en_s2_reg   <= '0;
         supp_s1_reg <= '0;
         supp_s2_reg <= '0;
         av_s1_reg   <= 1'b0;
         av_s2_reg   <= 1'b0;
         ad_s1_reg   <= '0;
         ad_s2_reg   <= '0;
         own_s1_reg  <= '0;
         own_s2_reg  <= '0;
      end else begin
         en_s1_reg   <= ch_enable;
         en_s2_reg   <= en_s1_reg;
         supp_s1_reg <= ch_supp;
         supp_s2_reg <= supp_s1_reg;
         av_s1_reg   <= adc_valid;
         av_s2_reg   <= av_s1_reg;
         ad_s1_reg   <= adc_data;
         ad_s2_reg   <= ad_s1_reg;
         own_s1_reg  <= tech_own;
         own_s2_reg  <= own_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [HIST_W-1:0] hist_back(input logic [HIST_W-1:0] idx, input int unsigned n);
      int unsigned t;
      t = int'(idx) + HIST_D - n;
      if (t >= HIST_D) begin
         t = t - HIST_D;
      end
      return HIST_W'(t);
   endfunction

   function automatic logic [DATA_W-1:0] mean_of(input logic [SUM_W-1:0] s, input int unsigned n);
      logic signed [SUM_W-1:0] q;
      q = $signed(s) / $signed(SUM_W'(n));
      return DATA_W'(q);
   endfunction

   logic                     fifo_in_ready;
   logic [HIST_W-1:0]        cur_idx;
   logic [DATA_W-1:0]        old20;
   logic [DATA_W-1:0]        old17;
   logic [SUM_W-1:0]         new50;
   logic [SUM_W-1:0]         new60;
   logic [1:0]               cur_supp;

   assign cur_idx  = st_reg.wr_idx[st_reg.ch*HIST_W +: HIST_W];
   assign cur_supp = supp_s2_reg[st_reg.ch*2 +: 2];
   assign old20    = hist_mem[int'(st_reg.ch)*HIST_D + int'(cur_idx)];
   assign old17    = hist_mem[int'(st_reg.ch)*HIST_D + int'(hist_back(cur_idx, WIN_60))];
   // running sums: add newest, drop the sample leaving each window
   assign new50 = st_reg.sum50[st_reg.ch*SUM_W +: SUM_W] + SUM_W'($signed(ad_s2_reg))
                  - SUM_W'($signed(old20));
   assign new60 = st_reg.sum60[st_reg.ch*SUM_W +: SUM_W] + SUM_W'($signed(ad_s2_reg))
                  - SUM_W'($signed(old17));

   // history clears at reset so the first means ramp up from zero instead of unknown
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_CH*HIST_D; i++) begin
            hist_mem[i] <= '0;
         end
      end else if (st_reg.state == ST_CONV && st_reg.adc_req && av_s2_reg) begin
         hist_mem[int'(st_reg.ch)*HIST_D + int'(cur_idx)] <= ad_s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // sequencer and word store
   always_comb begin
      st_next            = st_reg;
      st_next.push_valid = 1'b0;
      st_next.tick_cnt   = (st_reg.tick_cnt == TICK_LAST) ? '0 : st_reg.tick_cnt + 14'h1;
      case (st_reg.state)
         ST_IDLE: begin
            if (st_reg.tick_cnt == TICK_LAST) begin
               st_next.ch    = '0;
               st_next.state = ST_CONV;
            end
         end
         ST_CONV: begin
            if (!en_s2_reg[st_reg.ch]) begin
               // a request left standing would hand this sample to the next channel
               st_next.adc_req = 1'b0;
               st_next.state   = ST_PUSH;
            end else if (!st_reg.adc_req && !av_s2_reg) begin
               st_next.adc_req = 1'b1;
            end else if (st_reg.adc_req && av_s2_reg) begin
               st_next.adc_req = 1'b0;
               st_next.sum50[st_reg.ch*SUM_W +: SUM_W] = new50;
               st_next.sum60[st_reg.ch*SUM_W +: SUM_W] = new60;
               st_next.wr_idx[st_reg.ch*HIST_W +: HIST_W] =
                  (cur_idx == HIST_W'(HIST_D - 1)) ? '0 : cur_idx + 5'h1;
               case (cur_supp)
                  SUPP_60: st_next.result = mean_of(new60, WIN_60);
                  SUPP_400: st_next.result = ad_s2_reg;
                  default: st_next.result = mean_of(new50, WIN_50);
               endcase
               st_next.words[st_reg.ch*DATA_W +: DATA_W] = st_next.result;
               st_next.push_valid = 1'b1;
               st_next.state      = ST_PUSH;
            end
         end
         ST_PUSH: begin
            if (!st_reg.push_valid) begin
               st_next.ch    = st_reg.ch + 2'h1;
               st_next.state = (st_reg.ch == CH_W'(NUM_CH - 1)) ? ST_IDLE : ST_CONV;
            end
         end
         default: begin
            st_next.state = ST_IDLE;
         end
      endcase
      // samples stream out; a full fifo keeps the word and holds the stream copy until the next sample overwrites it
      if (st_reg.fifo_valid && fifo_in_ready) begin
         st_next.fifo_valid = 1'b0;
      end
      if (st_reg.push_valid) begin
         st_next.fifo_valid = 1'b1;
         st_next.fifo_ch    = st_reg.ch;
         st_next.fifo_data  = st_reg.result;
      end
      // stored word only changes when its channel's sample is taken, once per tick, so repeat reads match
      st_next.rd_word = st_reg.words[rd_ch*DATA_W +: DATA_W];
      if (wr_req) begin
         st_next.prog_words[int'(wr_sel)*DATA_W +: DATA_W] = wr_data;
      end
      for (int i = 0; i < NUM_OUT; i++) begin
         st_next.out_words[i*DATA_W +: DATA_W] = own_s2_reg[i] ? tech_data[i*DATA_W +: DATA_W]
                                                  : st_next.prog_words[i*DATA_W +: DATA_W];
      end
      if (wr_req && own_s2_reg[wr_sel]) begin
         st_next.prog_words[int'(wr_sel)*DATA_W +: DATA_W] =
            st_reg.prog_words[int'(wr_sel)*DATA_W +: DATA_W];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // outbound sample stream
   logic             fo_valid;
   logic [17:0]      fo_data;
   logic             wv_reg;
   logic [17:0]      wd_reg;

   aisf_fifo #(
      .WIDTH (DATA_W + CH_W),
      .DEPTH (FIFO_D),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .in_valid  (st_reg.fifo_valid),
      .in_ready  (fifo_in_ready),
      .in_data   ({st_reg.fifo_ch, st_reg.fifo_data}),
      .out_valid (fo_valid),
      .out_ready (!wv_reg || word_ready),
      .out_data  (fo_data)
   );

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wv_reg <= 1'b0;
         wd_reg <= '0;
      end else if (!wv_reg || word_ready) begin
         wv_reg <= fo_valid;
         // an empty fifo shows unwritten memory, so only a valid word is taken
         if (fo_valid) begin
            wd_reg <= fo_data;
         end
      end
   end

   assign word_valid         = wv_reg;
   assign word_ch            = wd_reg[17:16];
   assign word_data          = wd_reg[15:0];
   assign adc_req            = st_reg.adc_req;
   assign adc_ch             = st_reg.ch;
   assign periph_input_word  = st_reg.rd_word;
   assign periph_output_word = st_reg.out_words;
endmodule

//--- dv/aisf_adc_model.sv
/*
 converter model: four-phase sample handshake per channel
 assumes sample values and answer delay are set by the bench
*/
module aisf_adc_model (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic        adc_req,
   input  wire logic [1:0]  adc_ch,
   input  wire logic [63:0] sample_val,
   input  wire logic [3:0]  delay,
   output      logic        adc_valid = 1'b0,
   output      logic [15:0] adc_data = 16'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_reg = 4'h0;
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wait_reg <= 4'h0;
         adc_valid <= 1'b0;
      end else if (adc_req && !adc_valid) begin
         wait_reg <= wait_reg + 4'h1;
         if (wait_reg >= delay) begin
            wait_reg <= 4'h0;
            adc_valid <= 1'b1;
            adc_data <= sample_val[adc_ch*16+:16];
         end
      end else if (!adc_req && adc_valid) begin
         // released data is inverted so a stale sample never looks valid
         adc_valid <= 1'b0;
         adc_data <= ~adc_data;
      end
   end
endmodule

//--- dv/aisf_top_assertions.sv
/*
 checker for the sample filter: handshake, tick spacing, held words
 assumes it is bound to aisf_top and sees only its ports
*/
module aisf_top_assertions (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic        adc_req,
   input wire logic [1:0]  adc_ch,
   input wire logic        adc_valid,
   input wire logic [1:0]  rd_ch,
   input wire logic [15:0] periph_input_word,
   input wire logic        word_valid,
   input wire logic [1:0]  word_ch,
   input wire logic [15:0] word_data,
   input wire logic        word_ready,
   input wire logic [1:0]  tech_own,
   input wire logic [31:0] tech_data,
   input wire logic [31:0] periph_output_word
);
   typedef struct packed {
      logic        seen;
      logic        req;
      logic [13:0] cnt;
      logic [2:0]  own;
      logic [15:0] td;
   } aisf_chk_type;
   aisf_chk_type st_reg;
   aisf_chk_type st_next;
   logic         rise0;
   assign rise0 = adc_req && !st_reg.req && adc_ch == 2'h0;
   always_comb begin
      st_next = st_reg;
      st_next.req = adc_req;
      st_next.td = tech_data[15:0];
      st_next.cnt = (&st_reg.cnt) ? st_reg.cnt : st_reg.cnt + 14'h1;
      st_next.own = (&st_reg.own) ? st_reg.own : st_reg.own + 3'h1;
      // ownership only counts while the function's value sits still
      if (!tech_own[0] || tech_data[15:0] != st_reg.td) begin
         st_next.own = 3'h0;
      end
      if (rise0) begin
         st_next.seen = 1'b1;
         st_next.cnt = 14'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   ////////////////////////////////////////
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_req_held: assert property (adc_req && !adc_valid |=> adc_req)
      else $error("request dropped before data");
   a_req_release: assert property (adc_req && adc_valid |-> ##[1:5] !adc_req)
      else $error("request not released after data");
   a_rise_order: assert property ($rose(adc_req) |-> !adc_valid)
      else $error("request raised while data still valid");
   a_ch_stable: assert property (adc_req && $past(adc_req) |-> $stable(adc_ch))
      else $error("channel changed during conversion");
   a_tick_period: assert property (rise0 && st_reg.seen |-> st_reg.cnt == 14'h2710)
      else $error("sample period is not 10000 cycles");
   a_word_held: assert property ($changed(periph_input_word) && $past(rd_ch) == $past(rd_ch, 2)
      |-> $past(adc_valid) || $past(adc_valid, 2) || $past(adc_valid, 3) || $past(adc_valid, 4))
      else $error("input word changed between samples");
   a_stream_hold: assert property (word_valid && !word_ready |=> word_valid && $stable({word_ch, word_data}))
      else $error("stream word changed while stalled");
   a_owned_word: assert property (st_reg.own >= 3'h5 |-> periph_output_word[15:0] == tech_data[15:0])
      else $error("owned output not under function control");
endmodule
bind aisf_top aisf_top_assertions chk_u (.clk_sys, .reset_n, .adc_req, .adc_ch, .adc_valid, .rd_ch,
   .periph_input_word, .word_valid, .word_ch, .word_data, .word_ready, .tech_own, .tech_data, .periph_output_word);

//--- dv/testbench.sv
/*
 self-checking bench for the sample filter with a converter model
 assumes constant channel values so every running mean is predictable
*/
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import aisf_pkg::*;
   logic        clk_sys = 1'b0, reset_n = 1'b0, word_ready = 1'b1, mon_en = 1'b1;
   logic        wr_req = 1'b0, wr_sel = 1'b0, adc_req, adc_valid, word_valid;
   logic [1:0]  rd_ch = 2'h0, tech_own = 2'h0, adc_ch, word_ch;
   logic [3:0]  delay = 4'h1;
   logic [15:0] wr_data = 16'h0, adc_data, periph_input_word, word_data;
   logic [31:0] periph_output_word;
   logic [63:0] sample_val = {16'h0777, 16'h04d2, 16'hfc18, 16'h03e8};
   int          k[4] = '{default: 0};
   int          bad_count = 0, num_checks = 0, cycles = 0;
   always #50 clk_sys = ~clk_sys;
   aisf_adc_model model_u (.clk_sys, .reset_n, .adc_req, .adc_ch, .sample_val, .delay, .adc_valid, .adc_data);
   // ch3 disabled with the spare mode code; fifo copies must never show it
   aisf_top dut_u (.clk_sys, .reset_n, .ch_enable(4'h7), .ch_supp({2'h3, SUPP_400, SUPP_60, SUPP_50}),
      .adc_req, .adc_ch, .adc_valid, .adc_data, .rd_ch, .periph_input_word, .word_valid, .word_ch,
      .word_data, .word_ready, .wr_req, .wr_sel, .wr_data, .tech_own, .tech_data({16'ha5a5, 16'h5a5a}),
      .periph_output_word);
   ////////////////////////////////////////
   function automatic logic [15:0] exp_val(input int c, input int n);
      int v;
      int w;
      v = $signed(sample_val[c*16+:16]);
      w = (c == 0) ? WIN_50 : (c == 1) ? WIN_60 : 1;
      // history starts at zero, so the first means ramp up
      return 16'(((n < w ? n : w) * v) / w);
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #10;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (mon_en && word_valid === 1'b1 && word_ready) begin
         k[word_ch]++;
         `CHK(word_ch == 2'h3, 1'b0)
         `CHK(word_data, exp_val(word_ch, k[word_ch]))
      end
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 80000) begin
         bad_count++;
         summarize();
      end
   end
   ////////////////////////////////////////
   task automatic wr(input logic s, input logic [15:0] d);
      wr_sel = s;
      wr_data = d;
      wr_req = 1'b1;
      step(1);
      wr_req = 1'b0;
      step(1);
   endtask
   task automatic t_outputs;
      tech_own = 2'b01;
      step(6);
      wr(1'b1, 16'h1234);
      wr(1'b0, 16'h7777);
      step(4);
      `CHK(periph_output_word, {16'h1234, 16'h5a5a})
      tech_own = 2'b00;
      step(6);
      `CHK(periph_output_word, {16'h1234, 16'h0000})
      wr(1'b0, 16'h7777);
      step(4);
      `CHK(periph_output_word, {16'h1234, 16'h7777})
   endtask
   task automatic t_filter;
      logic [15:0] first;
      // four ticks keep the run short; the means are still ramping then
      while (k[2] < 4) step(1);
      `CHK(k[0] == k[2] && k[1] == k[2], 1'b1)
      for (int c = 2; c >= 0; c--) begin
         rd_ch = 2'(c);
         step(3);
         first = periph_input_word;
         `CHK(periph_input_word, exp_val(c, k[c]))
      end
      rd_ch = 2'h1;
      step(3);
      rd_ch = 2'h0;
      step(3);
      `CHK(periph_input_word, first)
   endtask
   task automatic t_fifo;
      int n;
      mon_en = 1'b0;
      word_ready = 1'b0;
      delay = 4'h7;
      for (n = 0; n < 9; n++) @(negedge adc_req);
      step(8);
      word_ready = 1'b1;
      n = 0;
      repeat (20) begin
         @(posedge clk_sys);
         if (word_valid === 1'b1) n++;
      end
      #10;
      // fifo depth plus the one word held in the output register
      `CHK(n == FIFO_D + 1, 1'b1)
      `CHK(word_valid, 1'b0)
   endtask
   initial begin
      step(12);
      reset_n = 1'b1;
      t_outputs();
      t_filter();
      t_fifo();
      summarize();
   end
endmodule
